// ===== uart_pin_strap_defaults.sv
`timescale 1ns/1ps
`default_nettype none
module uart_pin_strap_defaults (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic strap_primary_base_chan_a,
    input wire logic strap_alt_base_chan_a,
    input wire logic strap_config_port_select,
    input wire logic cfgWriteValid,
    input wire strap_defaults_pkg::cfg_write_t cfgWrite,
    input wire logic txActive,
    input wire logic txBit,
    input wire logic irActive,
    input wire logic irBit,
    input wire logic modemCtrlEnable,
    input wire logic requestToSend,
    input wire logic terminalReady,
    input wire logic [1:0] gpOut,
    input wire logic watchdogExpired,
    input wire logic chan_a_serial_in,
    input wire logic infrared_serial_in,
    input wire logic chan_a_clear_to_send_n,
    input wire logic chan_a_set_ready_n,
    input wire logic chan_a_carrier_detect_n,
    input wire logic chan_a_ring_ind_n,
    output logic chan_a_serial_out,
    output logic infrared_serial_out,
    output logic chan_a_request_to_send_n,
    output logic chan_a_terminal_ready_n,
    output logic watchdog_expire_n,
    output logic watchdogExpireOe,
    output strap_defaults_pkg::chan_cfg_t chanCfg,
    output strap_defaults_pkg::modem_status_t modemStatus,
    output logic rxLineIdle,
    output logic irLineIdle,
    output logic [7:0] cfgIndexPort,
    output logic [7:0] cfgDataPort,
    output logic strapsValid
);
    // Single clock domain; ref_clk stands in for the 24/48 MHz input [RQ10]

    strap_defaults_pkg::loader_state_t st_reg;
    strap_defaults_pkg::loader_state_t st_next;

    function automatic strap_defaults_pkg::chan_cfg_t strapCfg(
        input logic primary,
        input logic alt
    );
        strap_defaults_pkg::chan_cfg_t c;
        c = '0;
        // Primary wins when both straps are high
        if (primary) begin
            c.enable = strap_defaults_pkg::ENABLE_ON;
            c.baseHigh = strap_defaults_pkg::PRI_BASE_HIGH;
            c.baseLow = strap_defaults_pkg::PRI_BASE_LOW;
            c.irqSel = strap_defaults_pkg::PRI_IRQ;
        end else if (alt) begin
            c.enable = strap_defaults_pkg::ENABLE_ON;
            c.baseHigh = strap_defaults_pkg::ALT_BASE_HIGH;
            c.baseLow = strap_defaults_pkg::ALT_BASE_LOW;
            c.irqSel = strap_defaults_pkg::ALT_IRQ;
        end
        return c;
    endfunction

    // ==================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        case (st_reg.state)
            strap_defaults_pkg::ST_RESET: begin
                // Pins still carry strap levels, not driven values
                st_next.state = strap_defaults_pkg::ST_CAPTURE;
            end
            strap_defaults_pkg::ST_CAPTURE: begin
                st_next.strapPrimary = strap_primary_base_chan_a; // [RQ1] [RQ12]
                st_next.strapAlt = strap_alt_base_chan_a; // [RQ1] [RQ12]
                st_next.strapConfigPort = strap_config_port_select; // [RQ12]
                st_next.cfg = strapCfg(strap_primary_base_chan_a,
                    strap_alt_base_chan_a); // [RQ1]
                if (strap_config_port_select) begin // [RQ11]
                    st_next.cfgIndexPort = strap_defaults_pkg::CFG_INDEX_DEFAULT;
                    st_next.cfgDataPort = strap_defaults_pkg::CFG_DATA_DEFAULT;
                end else begin
                    st_next.cfgIndexPort = strap_defaults_pkg::CFG_INDEX_ALT;
                    st_next.cfgDataPort = strap_defaults_pkg::CFG_DATA_ALT;
                end
                st_next.state = strap_defaults_pkg::ST_RUN;
            end
            strap_defaults_pkg::ST_RUN: begin
                if (cfgWriteValid) begin // [RQ2]
                    case (cfgWrite.field)
                        2'h0: st_next.cfg.enable = cfgWrite.data;
                        2'h1: st_next.cfg.baseHigh = cfgWrite.data;
                        2'h2: st_next.cfg.baseLow = cfgWrite.data;
                        default: st_next.cfg.irqSel = cfgWrite.data;
                    endcase
                end
            end
            default: st_next.state = strap_defaults_pkg::ST_RESET;
        endcase
        // Pins only leave idle once straps are held
        if (st_reg.state == strap_defaults_pkg::ST_RUN) begin
            st_next.serialOut = txActive ? txBit : 1'b1; // [RQ3]
            st_next.infraredOut = irActive ? irBit : 1'b0; // [RQ4]
            // Active low as modem control, raw level as GPIO [RQ9]
            st_next.requestToSendN = modemCtrlEnable ? ~requestToSend : gpOut[0];
            st_next.terminalReadyN = modemCtrlEnable ? ~terminalReady : gpOut[1];
            st_next.watchdogOe = ~watchdogExpired; // [RQ7]
        end else begin
            st_next.serialOut = 1'b1; // [RQ3]
            st_next.infraredOut = 1'b0; // [RQ4]
            st_next.requestToSendN = 1'b1; // [RQ9]
            st_next.terminalReadyN = 1'b1;
            st_next.watchdogOe = 1'b1; // [RQ7]
        end
        // Asserted-high status, or raw levels as general purpose inputs [RQ8]
        st_next.status.clearToSend = modemCtrlEnable ? ~chan_a_clear_to_send_n
            : chan_a_clear_to_send_n;
        st_next.status.setReady = modemCtrlEnable ? ~chan_a_set_ready_n
            : chan_a_set_ready_n;
        st_next.status.carrierDetect = modemCtrlEnable ? ~chan_a_carrier_detect_n
            : chan_a_carrier_detect_n;
        st_next.status.ringInd = modemCtrlEnable ? ~chan_a_ring_ind_n
            : chan_a_ring_ind_n;
        st_next.rxIdle = chan_a_serial_in; // [RQ5]
        st_next.irIdle = ~infrared_serial_in; // [RQ6]
        if (reset) begin
            st_next = '0;
            st_next.state = strap_defaults_pkg::ST_RESET;
            st_next.serialOut = 1'b1; // [RQ3]
            st_next.requestToSendN = 1'b1;
            st_next.terminalReadyN = 1'b1;
            st_next.watchdogOe = 1'b1; // [RQ7]
            st_next.rxIdle = 1'b1;
            st_next.irIdle = 1'b1;
        end
    end

    // ==================================================
    // State register
    always_ff @(posedge ref_clk) begin
        st_reg <= st_next;
    end

    // ==================================================
    // Outputs direct from flops, except watchdog_expire_n tied low and strapsValid decoded from state
    assign chan_a_serial_out = st_reg.serialOut;
    assign infrared_serial_out = st_reg.infraredOut;
    assign chan_a_request_to_send_n = st_reg.requestToSendN;
    assign chan_a_terminal_ready_n = st_reg.terminalReadyN;
    // Open drain: data always low, enable low means pulling [RQ7]
    assign watchdog_expire_n = 1'b0;
    assign watchdogExpireOe = st_reg.watchdogOe;
    assign chanCfg = st_reg.cfg;
    assign modemStatus = st_reg.status;
    assign rxLineIdle = st_reg.rxIdle;
    assign irLineIdle = st_reg.irIdle;
    assign cfgIndexPort = st_reg.cfgIndexPort;
    assign cfgDataPort = st_reg.cfgDataPort;
    assign strapsValid = (st_reg.state == strap_defaults_pkg::ST_RUN);

endmodule // uart_pin_strap_defaults
`default_nettype wire

// ===== strap_defaults_pkg.sv
// Functional notes
// RQ1: Strap pins sampled at every reset pick each channel's default config values.
// RQ2: Strapped config values stay writable; a software write replaces the default.
// RQ3: Channel A serial output is 1 during reset and when idle.
// RQ4: Infrared output is 0 during reset and when idle.
// RQ5: Line driver idles serial input at 1; device treats 1 as idle.
// RQ6: Infrared receiver idles at 0; device treats 0 as no data.
// RQ7: Watchdog output is active low open drain, released when not asserted.
// RQ8: Modem status inputs are active low, or general purpose inputs.
// RQ9: Modem control outputs are active low, or general purpose outputs.
// RQ10: Device runs from one external 24 or 48 MHz clock; REF_CLOCK_MHZ here is set to 100.
// RQ11: Config port strap reads 1 without pull-down, choosing the default port pair.
// RQ12: Straps captured once at reset release, held until the next reset.
`default_nettype none
package strap_defaults_pkg;

    // ==================================================
    // Strap default values per pin state
    localparam logic [7:0] ENABLE_ON = 8'h01;
    localparam logic [7:0] ALT_BASE_HIGH = 8'h03;
    localparam logic [7:0] ALT_BASE_LOW = 8'he0;
    localparam logic [7:0] ALT_IRQ = 8'h03;
    localparam logic [7:0] PRI_BASE_HIGH = 8'h03;
    localparam logic [7:0] PRI_BASE_LOW = 8'hf8;
    localparam logic [7:0] PRI_IRQ = 8'h03;
    localparam logic [7:0] CFG_INDEX_DEFAULT = 8'h2e;
    localparam logic [7:0] CFG_DATA_DEFAULT = 8'h2f;
    localparam logic [7:0] CFG_INDEX_ALT = 8'h4e;
    localparam logic [7:0] CFG_DATA_ALT = 8'h4f;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ==================================================
    // Clock figures
    localparam int REF_CLOCK_MHZ = 100;

    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] baseHigh;
        logic [7:0] baseLow;
        logic [7:0] irqSel;
    } chan_cfg_t;

    typedef struct packed {
        logic [1:0] field;
        logic [7:0] data;
    } cfg_write_t;

    typedef struct packed {
        logic clearToSend;
        logic setReady;
        logic carrierDetect;
        logic ringInd;
    } modem_status_t;

    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_CAPTURE = 2'b01,
        ST_RUN = 2'b10
    } load_state_t;

    typedef struct packed {
        load_state_t state;
        logic strapPrimary;
        logic strapAlt;
        logic strapConfigPort;
        chan_cfg_t cfg;
        logic serialOut;
        logic infraredOut;
        logic requestToSendN;
        logic terminalReadyN;
        logic watchdogOe;
        modem_status_t status;
        logic rxIdle;
        logic irIdle;
        logic [7:0] cfgIndexPort;
        logic [7:0] cfgDataPort;
    } loader_state_t;

endpackage
`default_nettype wire

// ===== line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input wire logic [3:0] statusDrive,
    input wire logic lineBusy,
    input wire logic watchdog_expire_n,
    input wire logic watchdogExpireOe,
    output logic chan_a_serial_in,
    output logic infrared_serial_in,
    output logic chan_a_clear_to_send_n,
    output logic chan_a_set_ready_n,
    output logic chan_a_carrier_detect_n,
    output logic chan_a_ring_ind_n,
    output logic wdWire
);
    // ====
    // Far side lines
    // Mark idle, space while busy
    assign chan_a_serial_in = ~lineBusy;
    // Dark idle, lit while busy
    assign infrared_serial_in = lineBusy;
    // Modem pins asserted low
    assign {chan_a_clear_to_send_n, chan_a_set_ready_n,
        chan_a_carrier_detect_n, chan_a_ring_ind_n} = ~statusDrive;
    // Board pull-up wins once the drain lets go
    assign wdWire = watchdogExpireOe ? 1'b1 : watchdog_expire_n;
endmodule // line_partner
`default_nettype wire

// ===== strap_defaults_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module strap_defaults_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic strap_config_port_select,
    input wire logic cfgWriteValid,
    input wire strap_defaults_pkg::cfg_write_t cfgWrite,
    input wire logic txActive,
    input wire logic txBit,
    input wire logic irActive,
    input wire logic modemCtrlEnable,
    input wire logic requestToSend,
    input wire logic [1:0] gpOut,
    input wire logic watchdogExpired,
    input wire logic chan_a_serial_out,
    input wire logic infrared_serial_out,
    input wire logic chan_a_request_to_send_n,
    input wire logic chan_a_terminal_ready_n,
    input wire logic watchdog_expire_n,
    input wire logic watchdogExpireOe,
    input wire strap_defaults_pkg::chan_cfg_t chanCfg,
    input wire logic [7:0] cfgIndexPort,
    input wire logic strapsValid
);
    // ====
    // Port relations
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_tx_idle: assert property (!txActive |=> chan_a_serial_out)
        else $error("serial out not idle high");
    a_tx_data: assert property (txActive && strapsValid
        |=> chan_a_serial_out == $past(txBit)) else $error("serial out bit");
    a_ir_idle: assert property (!irActive |=> !infrared_serial_out)
        else $error("infrared out not idle low");
    a_wdog_drain: assert property (1'b1 |=> !watchdog_expire_n
        && watchdogExpireOe == !$past(watchdogExpired))
        else $error("watchdog drain wrong");
    a_rts_modem: assert property (strapsValid && modemCtrlEnable
        |=> chan_a_request_to_send_n == !$past(requestToSend))
        else $error("request to send polarity");
    a_ctrl_gpio: assert property (strapsValid && !modemCtrlEnable
        |=> {chan_a_terminal_ready_n, chan_a_request_to_send_n}
        == $past(gpOut)) else $error("general outputs wrong");
    a_strap_hold: assert property (strapsValid && !cfgWriteValid
        |=> $stable(chanCfg) && $stable(cfgIndexPort))
        else $error("strapped value moved");
    a_port_strap: assert property ($rose(strapsValid) |-> cfgIndexPort
        == ($past(strap_config_port_select)
        ? strap_defaults_pkg::CFG_INDEX_DEFAULT
        : strap_defaults_pkg::CFG_INDEX_ALT))
        else $error("index port strap wrong");
    a_write_lands: assert property (strapsValid && cfgWriteValid
        |=> chanCfg[31 - 8 * $past(cfgWrite.field) -: 8]
        == $past(cfgWrite.data)) else $error("config write lost");
endmodule // strap_defaults_monitor
bind uart_pin_strap_defaults strap_defaults_monitor monitor_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .strap_config_port_select(strap_config_port_select),
    .cfgWriteValid(cfgWriteValid),
    .cfgWrite(cfgWrite),
    .txActive(txActive),
    .txBit(txBit),
    .irActive(irActive),
    .modemCtrlEnable(modemCtrlEnable),
    .requestToSend(requestToSend),
    .gpOut(gpOut),
    .watchdogExpired(watchdogExpired),
    .chan_a_serial_out(chan_a_serial_out),
    .infrared_serial_out(infrared_serial_out),
    .chan_a_request_to_send_n(chan_a_request_to_send_n),
    .chan_a_terminal_ready_n(chan_a_terminal_ready_n),
    .watchdog_expire_n(watchdog_expire_n),
    .watchdogExpireOe(watchdogExpireOe),
    .chanCfg(chanCfg),
    .cfgIndexPort(cfgIndexPort),
    .strapsValid(strapsValid)
);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 0, reset = 1, cfgWriteValid = 0, txActive = 0, txBit = 0;
    logic irActive = 0, irBit = 0, modemCtrlEnable = 0, requestToSend = 0;
    logic terminalReady = 0, watchdogExpired = 0, strapsValid, wdWire;
    logic [1:0] gpOut = 0;
    logic [2:0] straps = 0;
    logic [3:0] statusDrive = 0;
    wire logic strap_config_port_select, strap_alt_base_chan_a;
    wire logic strap_primary_base_chan_a, chan_a_serial_in, infrared_serial_in;
    wire logic chan_a_clear_to_send_n, chan_a_set_ready_n, chan_a_ring_ind_n;
    wire logic chan_a_carrier_detect_n;
    logic chan_a_serial_out, infrared_serial_out, chan_a_request_to_send_n;
    logic chan_a_terminal_ready_n, watchdog_expire_n, watchdogExpireOe;
    logic rxLineIdle, irLineIdle;
    logic [7:0] cfgIndexPort, cfgDataPort;
    strap_defaults_pkg::cfg_write_t cfgWrite = '0;
    strap_defaults_pkg::chan_cfg_t chanCfg;
    strap_defaults_pkg::modem_status_t modemStatus;
    logic lineBusy = 0;
    int mismatches = 0, n_tests = 0;
    assign {strap_config_port_select, strap_alt_base_chan_a,
        strap_primary_base_chan_a} = straps;
    uart_pin_strap_defaults uart_pin_strap_defaults_i (.*);
    line_partner line_partner_i (
        .statusDrive(statusDrive),
        .lineBusy(lineBusy),
        .watchdog_expire_n(watchdog_expire_n),
        .watchdogExpireOe(watchdogExpireOe),
        .chan_a_serial_in(chan_a_serial_in),
        .infrared_serial_in(infrared_serial_in),
        .chan_a_clear_to_send_n(chan_a_clear_to_send_n),
        .chan_a_set_ready_n(chan_a_set_ready_n),
        .chan_a_carrier_detect_n(chan_a_carrier_detect_n),
        .chan_a_ring_ind_n(chan_a_ring_ind_n),
        .wdWire(wdWire)
    );
    always #5 ref_clk = ~ref_clk;
    // ====
    // Shared tasks
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset(logic [2:0] s);
        straps = s;
        reset = 1;
        step(16);
        check("serial out in reset", chan_a_serial_out, 1);
        check("ir out in reset", infrared_serial_out, 0);
        reset = 0;
        for (int k = 0; k < 8 && strapsValid !== 1'b1; k++) step();
        if (strapsValid !== 1'b1) begin
            mismatches++;
            give_verdict();
        end
    endtask
    // ====
    // Scenarios
    task automatic test_straps();
        logic [2:0] s[4] = '{3'h5, 3'h2, 3'h3, 3'h4};
        logic [31:0] exp;
        for (int i = 0; i < 4; i++) begin
            do_reset(s[i]);
            exp = s[i][0] ? 32'h0103f803 : (s[i][1] ? 32'h0103e003 : 0);
            check("strapped cfg", chanCfg, exp);
            check("index port", cfgIndexPort, s[i][2] ? 8'h2e : 8'h4e);
            check("data", cfgDataPort, s[i][2] ? 8'h2f : 8'h4f);
            straps = ~s[i];
            step(3);
            check("held cfg", chanCfg, exp);
        end
        $display("test_straps done");
    endtask
    task automatic test_write();
        do_reset(3'h4);
        cfgWrite = {2'h2, 8'ha5};
        cfgWriteValid = 1;
        step();
        cfgWrite = {2'h0, 8'h01};
        step();
        cfgWrite = {2'h1, 8'h5a};
        step();
        cfgWrite = {2'h3, 8'h07};
        step();
        cfgWriteValid = 0;
        step();
        check("written cfg", chanCfg, 32'h015aa507);
        $display("test_write done");
    endtask
    task automatic test_pins();
        txActive = 1;
        irActive = 1;
        irBit = 1;
        step(2);
        check("tx bit", {chan_a_serial_out, infrared_serial_out}, 2'h1);
        txActive = 0;
        irActive = 0;
        modemCtrlEnable = 1;
        requestToSend = 1;
        statusDrive = 4'ha;
        watchdogExpired = 1;
        step(2);
        check("idle tx", {chan_a_serial_out, infrared_serial_out}, 2'h2);
        check("ctrl", {chan_a_request_to_send_n,
            chan_a_terminal_ready_n}, 1);
        check("status", modemStatus, 4'ha);
        check("wdog low", wdWire, 0);
        check("line idle", {rxLineIdle, irLineIdle}, 2'h3);
        modemCtrlEnable = 0;
        gpOut = 2'h1;
        watchdogExpired = 0;
        lineBusy = 1;
        step(2);
        check("gp", {chan_a_request_to_send_n,
            chan_a_terminal_ready_n}, 2);
        check("line busy", {rxLineIdle, irLineIdle}, 2'h0);
        check("raw status", modemStatus, 4'h5);
        check("wdog released", wdWire, 1);
        $display("test_pins done");
    endtask
    initial begin
        test_straps();
        test_write();
        test_pins();
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
